// >>> logic/safety_actuation_voting.sv
// Coincidence voting plus manual block and unblock logic for a group of
// safety actuation outputs. Assumes inputs are synchronous to sys_clk.
//
// Overview of operation
// [RQ1] Flux doubling 2/4 vote; block needs criticality
// [RQ2] Flux block cleared when flux below permit
// [RQ3] Undervoltage: both sensors, two of four chargers
// [RQ4] High-2 level isolates; block only below permit
// [RQ5] Either generator high-2 level isolates makeup
// [RQ6] Safeguards with high-1 level isolates makeup
// [RQ7] Low-2 mean temperature vote blocks steam dump
// [RQ8] Injection valves follow fourth-stage depressurization
// [RQ9] Unblock below low permit, delayed reblock above
// [RQ10] Series recirc valves open on charger undervoltage
// [RQ11] All recirc open: depressurization with tank low
// [RQ12] Manual recirc opening needs two of four
// [RQ13] Hot leg low-1 isolates letdown; permit-gated block
// [RQ14] Makeup tank injection trips pressurizer heaters
// [RQ15] High-3 level trips heaters; permit-gated block
// [RQ16] Level-low permit active while level below setpoint
// [RQ17] Flux permit separates channels above and below
// [RQ18] Bypassed division excluded, coincidence kept while two or more remain active
// [RQ19] All state registered, reset to non-actuated
`timescale 1ns/10ps
`default_nettype none
module safety_actuation_voting
    import voting_pkg::*;
#(
    parameter int REBLOCK_CYCLES = REBLOCK_DELAY_MS * (CLK_HZ / 1000)
)(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [3:0] div_bypass,
    input  wire logic [3:0] flux_dbl_trip,
    input  wire logic [3:0] pzr_high2_trip,
    input  wire logic [3:0] sg1_high2_trip,
    input  wire logic [3:0] sg2_high2_trip,
    input  wire logic [3:0] pzr_high1_trip,
    input  wire logic [3:0] coolant_mean_temp_low2_trip,
    input  wire logic [3:0] refuel_tank_low3_trip,
    input  wire logic [3:0] pzr_high3_trip,
    input  wire logic [3:0] charger_uv_a,
    input  wire logic [3:0] charger_uv_b,
    input  wire logic [3:0] charger_ext_uv_a,
    input  wire logic [3:0] charger_ext_uv_b,
    input  wire logic [3:0] flux_above_p6,
    input  wire logic [3:0] level_below_p12,
    input  wire logic [3:0] level_above_p19,
    input  wire logic [1:0] hot_leg_low1,
    input  wire logic [1:0] hot_leg_low2,
    input  wire logic       plant_critical,
    input  wire logic       safeguards_auto,
    input  wire logic       safeguards_manual,
    input  wire logic       depress_stage4,
    input  wire logic       cmt_injection,
    input  wire logic [3:0] recirc_manual_ctl,
    input  wire logic       flux_block_req,
    input  wire logic       pzr_high2_block_req,
    input  wire logic       letdown_block_req,
    input  wire logic       pzr_high3_block_req,
    input  wire logic       inj_unblock_req,
    output logic            dilution_block,
    output logic            letdown_iso,
    output logic            makeup_iso,
    output logic            steam_dump_block,
    output logic            refuel_tank_inj_open,
    output logic            recirc_series_open,
    output logic            recirc_all_open,
    output logic            heater_trip,
    output logic [4:0]      block_flags,
    output logic [2:0]      permit_flags
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic             flux_blk;
        logic             pzr2_blk;
        logic             letdown_blk;
        logic             pzr3_blk;
        logic             inj_unblk;
        logic [CNT_W-1:0] reblock_cnt;
        logic             p6;
        logic             p12;
        logic             p19;
        logic             dilution;
        logic             letdown;
        logic             makeup;
        logic             dump_blk;
        logic             inj_open;
        logic             rc_series;
        logic             rc_all;
        logic             heater;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic [3:0] trips [N_VOTE];
    logic [N_VOTE-1:0] votes;

    assign trips[V_FLUX_DBL] = flux_dbl_trip;
    assign trips[V_PZR_HI2]  = pzr_high2_trip;
    assign trips[V_SG1_HI2]  = sg1_high2_trip;
    assign trips[V_SG2_HI2]  = sg2_high2_trip;
    assign trips[V_PZR_HI1]  = pzr_high1_trip;
    assign trips[V_TEMP_LO2] = coolant_mean_temp_low2_trip;
    assign trips[V_TANK_LO3] = refuel_tank_low3_trip;
    assign trips[V_PZR_HI3]  = pzr_high3_trip;

    // ------------------------------------------------------------
    // Bypass-capable voters
    // ------------------------------------------------------------
    vote_if vi [N_VOTE] ();

    generate
        for (genvar g = 0; g < N_VOTE; g++) begin : g_vote
            assign vi[g].trip   = trips[g];
            assign vi[g].bypass = div_bypass;
            assign votes[g]     = vi[g].vote;
            bypass_voter u_voter (.vi(vi[g]));
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic p6;
        logic p12;
        logic p19;
        logic uv_both;
        logic uv_ext;
        logic hot_leg_inj;
        p6          = two_of_four(flux_above_p6);                     // [RQ17]
        p12         = two_of_four(level_below_p12);                   // [RQ16]
        p19         = two_of_four(level_above_p19);
        uv_both     = two_of_four(charger_uv_a & charger_uv_b);       // [RQ3]
        uv_ext      = two_of_four(charger_ext_uv_a | charger_ext_uv_b);
        hot_leg_inj = &hot_leg_low2;
        st_nxt      = st_r;
        st_nxt.p6   = p6;
        st_nxt.p12  = p12;
        st_nxt.p19  = p19;

        // Block flags: P6 loss, or P19 or P12 present, clears; the gated request cannot collide
        if (!p6) begin
            st_nxt.flux_blk = 1'b0;                                    // [RQ2]
        end else if (flux_block_req && plant_critical) begin
            st_nxt.flux_blk = 1'b1;                                    // [RQ1]
        end
        if (p19) begin
            st_nxt.pzr2_blk = 1'b0;                                    // [RQ4]
            st_nxt.pzr3_blk = 1'b0;                                    // [RQ15]
        end else begin
            if (pzr_high2_block_req) begin
                st_nxt.pzr2_blk = 1'b1;                                // [RQ4]
            end
            if (pzr_high3_block_req) begin
                st_nxt.pzr3_blk = 1'b1;                                // [RQ15]
            end
        end
        if (p12) begin
            st_nxt.letdown_blk = 1'b0;                                 // [RQ13]
        end else if (letdown_block_req) begin
            st_nxt.letdown_blk = 1'b1;                                 // [RQ13]
        end

        // Injection unblock holds through short permit dips until the delay runs
        if (p12) begin
            st_nxt.reblock_cnt = CNT_ZERO;
            if (inj_unblock_req) begin
                st_nxt.inj_unblk = 1'b1;                               // [RQ9]
            end
        end else if (st_r.inj_unblk) begin
            if (st_r.reblock_cnt >= cnt_cast(REBLOCK_CYCLES) - CNT_ONE) begin
                st_nxt.inj_unblk   = 1'b0;                             // [RQ9]
                st_nxt.reblock_cnt = CNT_ZERO;
            end else begin
                st_nxt.reblock_cnt = st_r.reblock_cnt + CNT_ONE;
            end
        end

        // Actuation outputs use the current cycle's block flags
        st_nxt.dilution  = (votes[V_FLUX_DBL] && !st_r.flux_blk) || uv_both;     // [RQ1]
        st_nxt.letdown   = (votes[V_PZR_HI2] && !st_r.pzr2_blk)                  // [RQ4]
                         || (votes[V_FLUX_DBL] && !st_r.flux_blk)
                         || (|hot_leg_low1 && !st_r.letdown_blk);                // [RQ13]
        st_nxt.makeup    = (votes[V_PZR_HI2] && !st_r.pzr2_blk)                  // [RQ4]
                         || votes[V_SG1_HI2] || votes[V_SG2_HI2]                 // [RQ5]
                         || ((safeguards_auto || safeguards_manual)
                             && votes[V_PZR_HI1])                                // [RQ6]
                         || (votes[V_FLUX_DBL] && !st_r.flux_blk);
        st_nxt.dump_blk  = votes[V_TEMP_LO2];                                    // [RQ7]
        st_nxt.inj_open  = depress_stage4                                        // [RQ8]
                         || (hot_leg_inj && st_r.inj_unblk);                     // [RQ9]
        st_nxt.rc_series = uv_ext;                                               // [RQ10]
        st_nxt.rc_all    = (depress_stage4 && votes[V_TANK_LO3])                 // [RQ11]
                         || two_of_four(recirc_manual_ctl);                      // [RQ12]
        st_nxt.heater    = cmt_injection                                         // [RQ14]
                         || (votes[V_PZR_HI3] && !st_r.pzr3_blk);                // [RQ15]
    end

    function automatic logic [CNT_W-1:0] cnt_cast(input int v);
        cnt_cast = CNT_W'(v);
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;                                                // [RQ19]
        end else begin
            st_r <= st_nxt;                                            // [RQ19]
        end
    end

    assign dilution_block       = st_r.dilution;
    assign letdown_iso          = st_r.letdown;
    assign makeup_iso           = st_r.makeup;
    assign steam_dump_block     = st_r.dump_blk;
    assign refuel_tank_inj_open = st_r.inj_open;
    assign recirc_series_open   = st_r.rc_series;
    assign recirc_all_open      = st_r.rc_all;
    assign heater_trip          = st_r.heater;
    assign block_flags          = {st_r.inj_unblk, st_r.pzr3_blk, st_r.letdown_blk,
                                   st_r.pzr2_blk, st_r.flux_blk};
    assign permit_flags         = {st_r.p19, st_r.p12, st_r.p6};
endmodule
`default_nettype wire

// >>> include/voting_pkg.sv
// Constants shared by the actuation voting logic and its voter.
// Assumes one 25 MHz logic clock; all plant inputs already synchronous.
package voting_pkg;
    // ------------------------------------------------------------
    // Division and vote sizing
    // ------------------------------------------------------------
    localparam int N_DIV      = 4;
    localparam int N_CTL4     = 4;
    localparam int N_CTL2     = 2;
    localparam int VOTE_NEED  = 2;      // Coincidence required among active divisions
    localparam int N_VOTE     = 8;

    // Index of each bypass-capable vote
    localparam int V_FLUX_DBL = 0;
    localparam int V_PZR_HI2  = 1;
    localparam int V_SG1_HI2  = 2;
    localparam int V_SG2_HI2  = 3;
    localparam int V_PZR_HI1  = 4;
    localparam int V_TEMP_LO2 = 5;
    localparam int V_TANK_LO3 = 6;
    localparam int V_PZR_HI3  = 7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ              = 25_000_000;
    localparam int REBLOCK_DELAY_MS    = 1000;
    localparam int CNT_W               = 32;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;

    function automatic logic [2:0] count4(input logic [3:0] v);
        count4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
    endfunction

    // Plain two-of-four with no bypass
    function automatic logic two_of_four(input logic [3:0] v);
        two_of_four = count4(v) >= 3'(VOTE_NEED);
    endfunction
endpackage

// >>> include/vote_if.sv
// Carrier between the top voting logic and each bypass-capable voter.
// Assumes the user drives trip and bypass and reads vote combinationally.
`timescale 1ns/10ps
`default_nettype none
interface vote_if;
    logic [3:0] trip;
    logic [3:0] bypass;
    logic       vote;

    modport voter (input trip, input bypass, output vote);
    modport user  (output trip, output bypass, input vote);
endinterface
`default_nettype wire

// >>> logic/bypass_voter.sv
// Bypass-capable two-of-four coincidence voter, purely combinational.
// Assumes the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module bypass_voter
    import voting_pkg::*;
(
    vote_if.voter vi
);
    logic [3:0] active;
    logic [2:0] n_active;
    logic [2:0] n_trip;

    // Bypassed divisions are dropped; coincidence still needed while two or more of the rest remain
    assign active   = ~vi.bypass;
    assign n_active = count4(active);
    assign n_trip   = count4(vi.trip & active);
    // With a single division left, that one alone decides
    assign vi.vote  = (n_active >= 3'(VOTE_NEED)) ? (n_trip >= 3'(VOTE_NEED))
                                                   : (n_trip != 3'h0); // [RQ18]
endmodule
`default_nettype wire

// >>> sim/safety_actuation_voting_chk.sv
// Checker for the actuation voting block, bound to its top ports.
// Assumes one clock, sys_clk, and reset_n asynchronous active low.
`timescale 1ns/10ps
`default_nettype none
module safety_actuation_voting_chk (
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic [3:0] div_bypass,
    input wire logic [3:0] coolant_mean_temp_low2_trip,
    input wire logic [3:0] charger_ext_uv_a,
    input wire logic [3:0] charger_ext_uv_b,
    input wire logic [3:0] flux_above_p6,
    input wire logic [1:0] hot_leg_low1,
    input wire logic       plant_critical,
    input wire logic       depress_stage4,
    input wire logic       cmt_injection,
    input wire logic [3:0] recirc_manual_ctl,
    input wire logic       letdown_iso,
    input wire logic       steam_dump_block,
    input wire logic       refuel_tank_inj_open,
    input wire logic       recirc_series_open,
    input wire logic       recirc_all_open,
    input wire logic       heater_trip,
    input wire logic [4:0] block_flags
);
    // ----------
    // Properties
    // ----------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_dump_vote_on: assert property (div_bypass == 4'h0
        && $countones(coolant_mean_temp_low2_trip) > 1 |=> steam_dump_block) else $error("dump block missing");
    a_dump_vote_off: assert property (div_bypass == 4'h0
        && $countones(coolant_mean_temp_low2_trip) < 2 |=> !steam_dump_block) else $error("dump block spurious");
    a_inj_follows: assert property (depress_stage4 |=> refuel_tank_inj_open)
        else $error("injection valve not opened");
    a_heater_cmt: assert property (cmt_injection |=> heater_trip)
        else $error("heater trip missing");
    a_recirc_manual: assert property ($countones(recirc_manual_ctl) > 1 |=> recirc_all_open)
        else $error("manual recirc missing");
    a_series_uv: assert property ($countones(charger_ext_uv_a | charger_ext_uv_b) > 1
        |=> recirc_series_open) else $error("series recirc missing");
    a_flux_refuse: assert property ((!plant_critical) [*2] |=> !$rose(block_flags[0]))
        else $error("flux block taken while subcritical");
    a_flux_clear: assert property (($countones(flux_above_p6) < 2) [*2] |=> !block_flags[0])
        else $error("flux block kept below permit");
    a_letdown_low: assert property (hot_leg_low1 != 2'h0 && !block_flags[2] |=> letdown_iso)
        else $error("letdown isolation missing");
    a_reset_quiet: assert property (disable iff (1'b0) !reset_n |-> block_flags == 5'h00
        && !heater_trip && !recirc_all_open && !letdown_iso) else $error("output active in reset");
    c_reblock: cover property (block_flags[4] ##1 !block_flags[4]);
    c_recirc: cover property ($rose(recirc_all_open));
    c_dump: cover property ($rose(steam_dump_block));
endmodule
bind safety_actuation_voting safety_actuation_voting_chk i_safety_actuation_voting_chk (.*);
`default_nettype wire

// >>> sim/operator_panel.sv
// Operator recirculation controls, held as levels by the operator.
// Assumes the bench asks for switch positions through ctl_want.
`timescale 1ns/10ps
`default_nettype none
module operator_panel (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [3:0] ctl_want,
    output logic      [3:0] recirc_manual_ctl
);
    // One flop per switch: a real hand lags the request
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            recirc_manual_ctl <= 4'h0;
        end else begin
            recirc_manual_ctl <= ctl_want;
        end
    end
endmodule
`default_nettype wire

// >>> sim/safety_actuation_voting_tb.sv
// Self-checking bench for the actuation voting block.
// Assumes a short reblock delay so the run stays brief.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module safety_actuation_voting_tb;
    import voting_pkg::*;
    localparam int RB = 20;
    logic sys_clk = 0, reset_n = 1, plant_critical = 0, safeguards_auto = 0, safeguards_manual = 0;
    logic depress_stage4 = 0, cmt_injection = 0, flux_block_req = 0, pzr_high2_block_req = 0;
    logic letdown_block_req = 0, pzr_high3_block_req = 0, inj_unblock_req = 0;
    logic [3:0] div_bypass = 0, flux_dbl_trip = 0, pzr_high2_trip = 0, sg1_high2_trip = 0;
    logic [3:0] sg2_high2_trip = 0, pzr_high1_trip = 0, coolant_mean_temp_low2_trip = 0;
    logic [3:0] refuel_tank_low3_trip = 0, pzr_high3_trip = 0, charger_uv_a = 0, charger_uv_b = 0;
    logic [3:0] charger_ext_uv_a = 0, charger_ext_uv_b = 0, flux_above_p6 = 0, level_below_p12 = 0;
    logic [3:0] level_above_p19 = 0, ctl_want = 0, recirc_manual_ctl;
    logic [1:0] hot_leg_low1 = 0, hot_leg_low2 = 0;
    logic dilution_block, letdown_iso, makeup_iso, steam_dump_block, refuel_tank_inj_open;
    logic recirc_series_open, recirc_all_open, heater_trip;
    logic [4:0] block_flags;
    logic [2:0] permit_flags;
    int err_count = 0, total_checks = 0, cyc = 0;
    safety_actuation_voting #(.REBLOCK_CYCLES(RB)) i_safety_actuation_voting (.*);
    operator_panel i_operator_panel (.*);
    always #20 sys_clk = ~sys_clk;
    // ----------
    // Scenarios
    // ----------
    task finish_test;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task t_vote;
        @(posedge sys_clk) flux_dbl_trip <= 4'h3;
        coolant_mean_temp_low2_trip <= 4'h3;
        tick(1);
        `CHK("dilution", 1'b1, dilution_block)
        `CHK("dump", 1'b1, steam_dump_block)
        @(posedge sys_clk) div_bypass <= 4'h3;
        tick(1);
        `CHK("bypassed pair", 1'b0, dilution_block)
        @(posedge sys_clk) flux_dbl_trip <= 4'h4;
        tick(1);
        `CHK("one of two", 1'b0, dilution_block)
        @(posedge sys_clk) flux_dbl_trip <= 4'hc;
        tick(1);
        `CHK("two of two", 1'b1, dilution_block)
        @(posedge sys_clk) div_bypass <= 4'h0;
        flux_dbl_trip <= 4'h0;
        coolant_mean_temp_low2_trip <= 4'h0;
        pzr_high2_trip <= 4'h9;
        tick(1);
        `CHK("letdown hi2", 1'b1, letdown_iso)
        @(posedge sys_clk) pzr_high2_trip <= 4'h0;
        sg2_high2_trip <= 4'h5;
        tick(1);
        `CHK("makeup sg2", 1'b1, makeup_iso)
        @(posedge sys_clk) sg2_high2_trip <= 4'h0;
        pzr_high1_trip <= 4'h6;
        tick(1);
        `CHK("hi1 alone", 1'b0, makeup_iso)
        @(posedge sys_clk) safeguards_auto <= 1'b1;
        tick(1);
        `CHK("hi1 safeguards", 1'b1, makeup_iso)
        @(posedge sys_clk) safeguards_auto <= 1'b0;
        safeguards_manual <= 1'b1;
        tick(1);
        `CHK("hi1 manual", 1'b1, makeup_iso)
        @(posedge sys_clk) safeguards_manual <= 1'b0;
        pzr_high1_trip <= 4'h0;
        sg1_high2_trip <= 4'h3;
        tick(1);
        `CHK("makeup sg1", 1'b1, makeup_iso)
        @(posedge sys_clk) sg1_high2_trip <= 4'h0;
    endtask
    task t_block;
        @(posedge sys_clk) flux_above_p6 <= 4'hf;
        flux_block_req <= 1'b1;
        tick(3);
        `CHK("subcritical block", 1'b0, block_flags[0])
        @(posedge sys_clk) plant_critical <= 1'b1;
        tick(2);
        `CHK("critical block", 1'b1, block_flags[0])
        @(posedge sys_clk) flux_block_req <= 1'b0;
        flux_dbl_trip <= 4'h3;
        tick(1);
        `CHK("blocked dilution", 1'b0, dilution_block)
        @(posedge sys_clk) flux_above_p6 <= 4'h1;
        tick(3);
        `CHK("auto unblock", 1'b0, block_flags[0])
        `CHK("dilution back", 1'b1, dilution_block)
        @(posedge sys_clk) flux_dbl_trip <= 4'h0;
        plant_critical <= 1'b0;
    endtask
    task t_inj;
        @(posedge sys_clk) level_below_p12 <= 4'hf;
        inj_unblock_req <= 1'b1;
        tick(2);
        `CHK("unblock", 1'b1, block_flags[4])
        @(posedge sys_clk) inj_unblock_req <= 1'b0;
        hot_leg_low2 <= 2'h3;
        tick(2);
        `CHK("inj open", 1'b1, refuel_tank_inj_open)
        // Permit lost: flag must last exactly RB sampled edges
        @(posedge sys_clk) level_below_p12 <= 4'h0;
        tick(RB - 1);
        `CHK("delay holds", 1'b1, block_flags[4])
        `CHK("delay open", 1'b1, refuel_tank_inj_open)
        tick(1);
        `CHK("reblock", 1'b0, block_flags[4])
        tick(1);
        `CHK("inj shut", 1'b0, refuel_tank_inj_open)
        @(posedge sys_clk) hot_leg_low2 <= 2'h0;
        hot_leg_low1 <= 2'h2;
        tick(1);
        `CHK("hot leg low1", 1'b1, letdown_iso)
        @(posedge sys_clk) letdown_block_req <= 1'b1;
        tick(3);
        `CHK("letdown block", 1'b0, letdown_iso)
        @(posedge sys_clk) letdown_block_req <= 1'b0;
        hot_leg_low1 <= 2'h0;
        level_below_p12 <= 4'h3;
        tick(2);
        `CHK("letdown unblock", 1'b0, block_flags[2])
    endtask
    task t_recirc;
        @(posedge sys_clk) charger_ext_uv_a <= 4'h1;
        charger_ext_uv_b <= 4'h2;
        tick(1);
        `CHK("series", 1'b1, recirc_series_open)
        @(posedge sys_clk) charger_ext_uv_b <= 4'h1;
        depress_stage4 <= 1'b1;
        refuel_tank_low3_trip <= 4'ha;
        tick(1);
        `CHK("one charger", 1'b0, recirc_series_open)
        `CHK("all open", 1'b1, recirc_all_open)
        `CHK("inj follows", 1'b1, refuel_tank_inj_open)
        @(posedge sys_clk) depress_stage4 <= 1'b0;
        ctl_want <= 4'h1;
        cmt_injection <= 1'b1;
        tick(2);
        `CHK("one control", 1'b0, recirc_all_open)
        `CHK("heater", 1'b1, heater_trip)
        @(posedge sys_clk) ctl_want <= 4'h5;
        charger_uv_a <= 4'h3;
        charger_uv_b <= 4'h6;
        tick(2);
        `CHK("two controls", 1'b1, recirc_all_open)
        `CHK("uv one charger", 1'b0, dilution_block)
        @(posedge sys_clk) charger_uv_b <= 4'h3;
        tick(1);
        `CHK("uv two chargers", 1'b1, dilution_block)
    endtask
    task t_level;
        @(posedge sys_clk) cmt_injection <= 1'b0;
        ctl_want <= 4'h0;
        charger_uv_b <= 4'h0;
        flux_above_p6 <= 4'h3;
        level_below_p12 <= 4'h0;
        pzr_high2_block_req <= 1'b1;
        pzr_high3_block_req <= 1'b1;
        tick(2);
        `CHK("hi2 block", 1'b1, block_flags[1])
        `CHK("hi3 block", 1'b1, block_flags[3])
        `CHK("flux permit", 3'h1, permit_flags)
        @(posedge sys_clk) pzr_high2_block_req <= 1'b0;
        pzr_high3_block_req <= 1'b0;
        pzr_high2_trip <= 4'h3;
        pzr_high3_trip <= 4'h3;
        tick(1);
        `CHK("hi2 blocked", 1'b0, letdown_iso)
        `CHK("hi3 blocked", 1'b0, heater_trip)
        @(posedge sys_clk) level_above_p19 <= 4'hc;
        tick(2);
        `CHK("hi2 unblocked", 1'b1, letdown_iso)
        `CHK("hi3 unblocked", 1'b1, heater_trip)
        `CHK("high permit", 3'h5, permit_flags)
        @(posedge sys_clk) level_below_p12 <= 4'h6;
        pzr_high3_block_req <= 1'b1;
        tick(2);
        `CHK("hi3 refused", 1'b0, block_flags[3])
        `CHK("low permit", 1'b1, permit_flags[1])
        @(posedge sys_clk) pzr_high3_block_req <= 1'b0;
        level_above_p19 <= 4'h0;
        level_below_p12 <= 4'h0;
        pzr_high2_trip <= 4'h0;
        pzr_high3_trip <= 4'h0;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        // Falling edge at time zero so the asynchronous reset clears state
        reset_n <= 1'b0;
        tick(3);
        `CHK("reset blocks", 5'h00, block_flags)
        `CHK("reset heater", 1'b0, heater_trip)
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_vote();
        t_block();
        t_inj();
        t_recirc();
        t_level();
        finish_test();
    end
endmodule
`default_nettype wire
